// file: rtl/dcdc_pkg.sv
/*
  Shared constants for the data compare debug control block: special
  register numbers, control and status field positions, reset values.
  Assumes bit 0 of every documented register is the vector's bit 31.
*/
package dcdc_pkg;
  localparam int unsigned SPR_W = 10;
  localparam int unsigned DW    = 32;

  // Special register numbers
  localparam logic [9:0] SPR_CTRL   = 10'h3BD;
  localparam logic [9:0] SPR_STATUS = 10'h3F0;
  localparam logic [9:0] SPR_ADDR_A = 10'h3F6;
  localparam logic [9:0] SPR_ADDR_B = 10'h3F7;
  localparam logic [9:0] SPR_VAL_A  = 10'h3B6;
  localparam logic [9:0] SPR_VAL_B  = 10'h3B7;

  // Control field positions (vector index = 31 - documented bit)
  localparam int unsigned CTL_A_RD    = 31;
  localparam int unsigned CTL_B_RD    = 30;
  localparam int unsigned CTL_A_WR    = 29;
  localparam int unsigned CTL_B_WR    = 28;
  localparam int unsigned CTL_A_GRAN  = 26;
  localparam int unsigned CTL_B_GRAN  = 24;
  localparam int unsigned CTL_RANGE   = 23;
  localparam int unsigned CTL_EXCL    = 22;
  localparam int unsigned CTL_A_MODE  = 18;
  localparam int unsigned CTL_B_MODE  = 16;
  localparam int unsigned CTL_A_BSEL  = 12;
  localparam int unsigned CTL_B_BSEL  = 8;
  localparam logic [31:0] CTL_WMASK   = 32'hFFCFFF00;
  localparam logic [31:0] CTL_RESET   = 32'h00000000;

  // Status flag positions
  localparam int unsigned STS_A_RD    = 24;
  localparam int unsigned STS_A_WR    = 23;
  localparam int unsigned STS_B_RD    = 22;
  localparam int unsigned STS_B_WR    = 21;
  localparam logic [31:0] STS_RESET   = 32'h00000000;
  localparam logic [31:0] CMP_RESET   = 32'h00000000;

  // Granularity and value match encodings
  typedef enum logic [1:0] {
    DCDC_GRAN_BYTE = 2'b00,
    DCDC_GRAN_HALF = 2'b01,
    DCDC_GRAN_WORD = 2'b10,
    DCDC_GRAN_LINE = 2'b11
  } dcdc_gran_e;

  typedef enum logic [1:0] {
    DCDC_VM_UNDEF = 2'b00,
    DCDC_VM_ALL   = 2'b01,
    DCDC_VM_BYTE  = 2'b10,
    DCDC_VM_HALF  = 2'b11
  } dcdc_vmode_e;
endpackage : dcdc_pkg

// file: rtl/dcdc_addr_match.sv
/*
  Exact data address match with selectable low-bit granularity.
  Assumes a full 32-bit effective address from the load/store unit.
*/
`timescale 1ns/1ps
module dcdc_addr_match
  import dcdc_pkg::*;
(
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] cmp_i,
  input  wire logic [1:0]  gran_i,
  output logic             hit_o
);
  logic [31:0] care;

  // Low address bits dropped per granularity setting
  assign care = (gran_i == DCDC_GRAN_BYTE) ? 32'hFFFFFFFF :
                (gran_i == DCDC_GRAN_HALF) ? 32'hFFFFFFFE :
                (gran_i == DCDC_GRAN_WORD) ? 32'hFFFFFFFC : 32'hFFFFFFE0;
  assign hit_o = ((addr_i ^ cmp_i) & care) == 32'h00000000;
endmodule : dcdc_addr_match

// file: rtl/dcdc_value_match.sv
/*
  Data value compare of one access against one compare register.
  Assumes byte select bit 3 covers the most significant data byte.
*/
`timescale 1ns/1ps
module dcdc_value_match
  import dcdc_pkg::*;
(
  input  wire logic [31:0] data_i,
  input  wire logic [31:0] cmp_i,
  input  wire logic [3:0]  bsel_i,
  input  wire logic [1:0]  mode_i,
  output logic             hit_o
);
  logic [3:0] eq;
  logic [3:0] sel_eq;
  logic       all_hit;
  logic       byte_hit;
  logic       half_hit;

  genvar k;
  for (k = 0; k < 4; k++) begin : g_lane
    assign eq[k] = data_i[8*k +: 8] == cmp_i[8*k +: 8];
  end

  assign sel_eq   = eq & bsel_i;
  assign all_hit  = (sel_eq == bsel_i);
  assign byte_hit = |sel_eq;
  // A halfword counts only when both its bytes are selected
  assign half_hit = (&bsel_i[3:2] & &eq[3:2]) | (&bsel_i[1:0] & &eq[1:0]);
  // No bytes selected or undefined mode never matches
  assign hit_o = (bsel_i != 4'h0) &
                 ((mode_i == DCDC_VM_ALL)  ? all_hit  :
                  (mode_i == DCDC_VM_BYTE) ? byte_hit :
                  (mode_i == DCDC_VM_HALF) ? half_hit : 1'b0);
endmodule : dcdc_value_match

// file: rtl/dcdc_core.sv
/*
  Data compare debug control: control register, two address compare
  registers, two value compare registers and the data event status
  flags, reached by move-to and move-from special register strobes.
  Assumes single-cycle strobes and access qualifiers from the core
  pipeline on sys_clk_i; no synchronisers are needed.
*/
// Contract
// [R01] Control bit 0 and bit 1 enable load events of address comparators A and B.
// [R02] Control bit 2 and bit 3 enable store events of address comparators A and B.
// [R03] Field 4:5 picks comparator A's granularity: all, ignore one, two or five low bits.
// [R04] Field 6:7 picks comparator B's granularity with the same encoding.
// [R05] Bit 8 makes both address registers one range used by both comparators' events.
// [R06] Bit 9 makes that range exclusive, so addresses outside it match.
// [R07] Field 12:13 sets value comparator A's mode: all bytes, any byte, any halfword.
// [R08] Field 14:15 sets value comparator B's mode with the same encoding.
// [R09] Field 16:19 selects bytes of value register A; all zero disables its event.
// [R10] Field 20:23 selects bytes of value register B; all zero disables its event.
// [R11] The control register is special register 957, read and written by move strobes.
// [R12] Each address compare register holds any full 32-bit byte address.
// [R13] A matching load or store on either comparator sets its own status flag.
// [R14] Bit 0 is the register's MSB; reserved bits read zero and ignore writes.
// [R15] The control register resets to zero, disabling every event.
`timescale 1ns/1ps
module dcdc_core
  import dcdc_pkg::*;
(
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [dcdc_pkg::SPR_W-1:0] spr_num_i,
  input  wire logic                      spr_read_i,
  input  wire logic                      spr_write_i,
  input  wire logic [dcdc_pkg::DW-1:0]    spr_wdata_i,
  output logic      [dcdc_pkg::DW-1:0]    spr_rdata_o,
  output logic                           spr_ack_o,
  input  wire logic                      acc_valid_i,
  input  wire logic                      acc_store_i,
  input  wire logic [dcdc_pkg::DW-1:0]    acc_addr_i,
  input  wire logic [dcdc_pkg::DW-1:0]    acc_data_i,
  output logic                           addr_a_read_event_o,
  output logic                           addr_a_write_event_o,
  output logic                           addr_b_read_event_o,
  output logic                           addr_b_write_event_o,
  output logic                           value_a_event_o,
  output logic                           value_b_event_o,
  output logic      [dcdc_pkg::DW-1:0]    debug_event_status_o
);
  import dcdc_pkg::*;

  logic [31:0] data_debug_compare_control;
  logic [31:0] data_addr_compare_first;
  logic [31:0] data_addr_compare_second;
  logic [31:0] data_value_compare_first;
  logic [31:0] data_value_compare_second;
  logic [31:0] debug_event_status;

  // Decoded control fields
  wire         addr_cmp_a_read_enable  = data_debug_compare_control[CTL_A_RD];
  wire         addr_cmp_b_read_enable  = data_debug_compare_control[CTL_B_RD];
  wire         addr_cmp_a_write_enable = data_debug_compare_control[CTL_A_WR];
  wire         addr_cmp_b_write_enable = data_debug_compare_control[CTL_B_WR];
  wire [1:0]   addr_cmp_a_granularity  = data_debug_compare_control[CTL_A_GRAN +: 2];
  wire [1:0]   addr_cmp_b_granularity  = data_debug_compare_control[CTL_B_GRAN +: 2];
  wire         addr_range_enable       = data_debug_compare_control[CTL_RANGE];
  wire         addr_range_exclusive    = data_debug_compare_control[CTL_EXCL];
  wire [1:0]   value_cmp_a_match_mode  = data_debug_compare_control[CTL_A_MODE +: 2];
  wire [1:0]   value_cmp_b_match_mode  = data_debug_compare_control[CTL_B_MODE +: 2];
  wire [3:0]   value_cmp_a_byte_select = data_debug_compare_control[CTL_A_BSEL +: 4];
  wire [3:0]   value_cmp_b_byte_select = data_debug_compare_control[CTL_B_BSEL +: 4];

  // Special register decode
  wire sel_ctrl   = spr_num_i == SPR_CTRL;
  wire sel_status = spr_num_i == SPR_STATUS;
  wire sel_addr_a = spr_num_i == SPR_ADDR_A;
  wire sel_addr_b = spr_num_i == SPR_ADDR_B;
  wire sel_val_a  = spr_num_i == SPR_VAL_A;
  wire sel_val_b  = spr_num_i == SPR_VAL_B;
  wire sel_any    = sel_ctrl | sel_status | sel_addr_a | sel_addr_b | sel_val_a | sel_val_b;

  wire wr_ctrl    = spr_write_i & sel_ctrl;   // R11
  wire wr_status  = spr_write_i & sel_status;
  wire wr_addr_a  = spr_write_i & sel_addr_a;
  wire wr_addr_b  = spr_write_i & sel_addr_b;
  wire wr_val_a   = spr_write_i & sel_val_a;
  wire wr_val_b   = spr_write_i & sel_val_b;

  // Address comparators
  logic exact_a;
  logic exact_b;

  dcdc_addr_match u_addr_a (
    .addr_i (acc_addr_i),
    .cmp_i  (data_addr_compare_first),
    .gran_i (addr_cmp_a_granularity),   // R03
    .hit_o  (exact_a)
  );

  dcdc_addr_match u_addr_b (
    .addr_i (acc_addr_i),
    .cmp_i  (data_addr_compare_second),
    .gran_i (addr_cmp_b_granularity),   // R04
    .hit_o  (exact_b)
  );

  // Range is low bound inclusive, high bound not included
  wire in_range  = (acc_addr_i >= data_addr_compare_first) &
                   (acc_addr_i <  data_addr_compare_second);
  wire range_hit = addr_range_exclusive ? ~in_range : in_range;   // R06
  wire match_a   = addr_range_enable ? range_hit : exact_a;   // R05
  wire match_b   = addr_range_enable ? range_hit : exact_b;   // R05

  wire acc_load  = acc_valid_i & ~acc_store_i;
  wire acc_store = acc_valid_i & acc_store_i;

  wire next_a_rd = acc_load  & addr_cmp_a_read_enable  & match_a;   // R01
  wire next_b_rd = acc_load  & addr_cmp_b_read_enable  & match_b;   // R01
  wire next_a_wr = acc_store & addr_cmp_a_write_enable & match_a;   // R02
  wire next_b_wr = acc_store & addr_cmp_b_write_enable & match_b;   // R02

  // Value comparators
  logic vhit_a;
  logic vhit_b;

  dcdc_value_match u_val_a (
    .data_i (acc_data_i),
    .cmp_i  (data_value_compare_first),
    .bsel_i (value_cmp_a_byte_select),   // R09
    .mode_i (value_cmp_a_match_mode),    // R07
    .hit_o  (vhit_a)
  );

  dcdc_value_match u_val_b (
    .data_i (acc_data_i),
    .cmp_i  (data_value_compare_second),
    .bsel_i (value_cmp_b_byte_select),   // R10
    .mode_i (value_cmp_b_match_mode),    // R08
    .hit_o  (vhit_b)
  );

  wire next_va = acc_valid_i & vhit_a;   // R09
  wire next_vb = acc_valid_i & vhit_b;   // R10

  // Status: address events set flags, write of ones clears; set beats clear
  logic flag_a_rd;
  logic flag_a_wr;
  logic flag_b_rd;
  logic flag_b_wr;

  wire clr_a_rd       = wr_status & spr_wdata_i[STS_A_RD];
  wire clr_a_wr       = wr_status & spr_wdata_i[STS_A_WR];
  wire clr_b_rd       = wr_status & spr_wdata_i[STS_B_RD];
  wire clr_b_wr       = wr_status & spr_wdata_i[STS_B_WR];
  wire next_flag_a_rd = next_a_rd | (flag_a_rd & ~clr_a_rd);   // R13
  wire next_flag_a_wr = next_a_wr | (flag_a_wr & ~clr_a_wr);   // R13
  wire next_flag_b_rd = next_b_rd | (flag_b_rd & ~clr_b_rd);   // R13
  wire next_flag_b_wr = next_b_wr | (flag_b_wr & ~clr_b_wr);   // R13

  // Unused status bits keep their reset value and read zero
  always_comb begin
    debug_event_status           = STS_RESET;
    debug_event_status[STS_A_RD] = flag_a_rd;
    debug_event_status[STS_A_WR] = flag_a_wr;
    debug_event_status[STS_B_RD] = flag_b_rd;
    debug_event_status[STS_B_WR] = flag_b_wr;
  end

  // Control write keeps reserved bits at zero
  wire [31:0] next_ctrl = spr_wdata_i & CTL_WMASK;   // R14

  // Read mux; unmapped numbers read zero with no acknowledge
  wire [31:0] next_rdata =
    sel_ctrl   ? data_debug_compare_control :   // R11
    sel_status ? debug_event_status :
    sel_addr_a ? data_addr_compare_first :
    sel_addr_b ? data_addr_compare_second :
    sel_val_a  ? data_value_compare_first :
    sel_val_b  ? data_value_compare_second : 32'h00000000;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_debug_compare_control <= CTL_RESET;   // R15
    end else if (wr_ctrl) begin
      data_debug_compare_control <= next_ctrl;   // R11
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_addr_compare_first  <= CMP_RESET;
      data_addr_compare_second <= CMP_RESET;
    end else begin
      if (wr_addr_a) begin
        data_addr_compare_first <= spr_wdata_i;   // R12
      end
      if (wr_addr_b) begin
        data_addr_compare_second <= spr_wdata_i;   // R12
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_value_compare_first  <= CMP_RESET;
      data_value_compare_second <= CMP_RESET;
    end else begin
      if (wr_val_a) begin
        data_value_compare_first <= spr_wdata_i;
      end
      if (wr_val_b) begin
        data_value_compare_second <= spr_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_a_rd <= STS_RESET[STS_A_RD];
    end else begin
      flag_a_rd <= next_flag_a_rd;   // R13
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_a_wr <= STS_RESET[STS_A_WR];
    end else begin
      flag_a_wr <= next_flag_a_wr;   // R13
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_b_rd <= STS_RESET[STS_B_RD];
    end else begin
      flag_b_rd <= next_flag_b_rd;   // R13
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_b_wr <= STS_RESET[STS_B_WR];
    end else begin
      flag_b_wr <= next_flag_b_wr;   // R13
    end
  end

  // Read data held until the next read; acknowledge is one pulse
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spr_ack_o <= 1'b0;
    end else begin
      spr_ack_o <= (spr_read_i | spr_write_i) & sel_any;   // R11
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spr_rdata_o <= 32'h00000000;
    end else if (spr_read_i) begin
      spr_rdata_o <= next_rdata;   // R11
    end
  end

  // Registered event pulses, one cycle after the access
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_a_read_event_o <= 1'b0;
    end else begin
      addr_a_read_event_o <= next_a_rd;   // R01
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_a_write_event_o <= 1'b0;
    end else begin
      addr_a_write_event_o <= next_a_wr;   // R02
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_b_read_event_o <= 1'b0;
    end else begin
      addr_b_read_event_o <= next_b_rd;   // R01
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_b_write_event_o <= 1'b0;
    end else begin
      addr_b_write_event_o <= next_b_wr;   // R02
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_a_event_o <= 1'b0;
    end else begin
      value_a_event_o <= next_va;   // R09
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_b_event_o <= 1'b0;
    end else begin
      value_b_event_o <= next_vb;   // R10
    end
  end

  assign debug_event_status_o = debug_event_status;
endmodule : dcdc_core

// file: tb/dcdc_core_props.sv
/* Port checker for dcdc_core.
   Bound into every dcdc_core; sees only that module's ports. */
`timescale 1ns/1ps
module dcdc_core_props
  import dcdc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic [9:0]  spr_num_i,
  input wire logic        spr_read_i,
  input wire logic        spr_write_i,
  input wire logic [31:0] spr_wdata_i,
  input wire logic [31:0] spr_rdata_o,
  input wire logic        spr_ack_o,
  input wire logic        acc_valid_i,
  input wire logic        acc_store_i,
  input wire logic        addr_a_read_event_o,
  input wire logic        addr_a_write_event_o,
  input wire logic        addr_b_read_event_o,
  input wire logic        addr_b_write_event_o,
  input wire logic        value_a_event_o,
  input wire logic        value_b_event_o,
  input wire logic [31:0] debug_event_status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence ctl_wr_s; spr_write_i && spr_num_i == SPR_CTRL; endsequence
  sequence ctl_rd_s; spr_read_i && !spr_write_i && spr_num_i == SPR_CTRL; endsequence
  AST_ACK_CTRL: assert property (ctl_wr_s or ctl_rd_s |=> spr_ack_o)
    else $error("no ack after control access");
  AST_ACK_CAUSE: assert property (spr_ack_o |-> $past(spr_read_i) || $past(spr_write_i))
    else $error("ack without request");
  // Gap cycle matches the bench's transfer spacing
  AST_CTRL_RDBACK: assert property (ctl_wr_s ##1 !spr_write_i ##1 ctl_rd_s |=>
    spr_rdata_o == ($past(spr_wdata_i, 3) & CTL_WMASK)) else $error("control readback wrong");
  AST_LOAD_EVT: assert property (addr_a_read_event_o || addr_b_read_event_o |->
    $past(acc_valid_i) && !$past(acc_store_i)) else $error("load event without load");
  AST_STORE_EVT: assert property (addr_a_write_event_o || addr_b_write_event_o |->
    $past(acc_valid_i) && $past(acc_store_i)) else $error("store event without store");
  AST_VAL_EVT: assert property (value_a_event_o || value_b_event_o |-> $past(acc_valid_i))
    else $error("value event without access");
  AST_STS_SET: assert property (addr_b_write_event_o |-> debug_event_status_o[STS_B_WR])
    else $error("status flag not set");
  AST_STS_HOLD: assert property ($fell(debug_event_status_o[STS_A_RD]) |->
    $past(spr_write_i) && $past(spr_num_i) == SPR_STATUS) else $error("status flag lost");
  AST_RST_ZERO: assert property ($rose(reset_n_i) |-> debug_event_status_o == STS_RESET)
    else $error("status not clear after reset");
endmodule : dcdc_core_props
bind dcdc_core dcdc_core_props dcdc_core_props_inst (
  .sys_clk_i, .reset_n_i, .spr_num_i, .spr_read_i, .spr_write_i, .spr_wdata_i,
  .spr_rdata_o, .spr_ack_o, .acc_valid_i, .acc_store_i, .addr_a_read_event_o,
  .addr_a_write_event_o, .addr_b_read_event_o, .addr_b_write_event_o,
  .value_a_event_o, .value_b_event_o, .debug_event_status_o);

// file: tb/dcdc_core_model.sv
/* Core-side partner: supervisor move strobes and load/store accesses.
   Assumes the block's clock; drives 1 ns after rising edges. */
`timescale 1ns/1ps
module dcdc_core_model (
  input  wire logic   sys_clk_i,
  output logic [9:0]  spr_num_o,
  output logic        spr_read_o,
  output logic        spr_write_o,
  output logic [31:0] spr_wdata_o,
  output logic        acc_valid_o,
  output logic        acc_store_o,
  output logic [31:0] acc_addr_o,
  output logic [31:0] acc_data_o
);
  initial {spr_num_o, spr_read_o, spr_write_o, spr_wdata_o,
           acc_valid_o, acc_store_o, acc_addr_o, acc_data_o} = '0;
  // Released number, data and address lines show the inverse; strobes drop to zero and acc_store_o keeps its value
  task automatic spr(input logic rd, input logic wr, input logic [9:0] n,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    #1;
    spr_num_o = n;
    spr_wdata_o = d;
    spr_read_o = rd;
    spr_write_o = wr;
    @(posedge sys_clk_i);
    #1;
    spr_read_o = 1'b0;
    spr_write_o = 1'b0;
    spr_num_o = ~n;
    spr_wdata_o = ~d;
  endtask : spr
  task automatic access(input logic st, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    #1;
    acc_store_o = st;
    acc_addr_o = a;
    acc_data_o = d;
    acc_valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    acc_valid_o = 1'b0;
    acc_addr_o = ~a;
    acc_data_o = ~d;
  endtask : access
endmodule : dcdc_core_model

// file: tb/data_compare_debug_control_tb_top.sv
/* Self-checking bench: dcdc_core against a behavioural model.
   Assumes dcdc_core_model drives the core side; checker is bound. */
`timescale 1ns/1ps
module data_compare_debug_control_tb_top
  import dcdc_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  wire  [9:0]  num;
  wire         srd, swr, av, ast, ack;
  wire  [31:0] wd, rdat, aa, ad, sts;
  wire  [5:0]  evt;
  logic [31:0] m_ctrl, m_a, m_b, m_va, m_vb, m_sts, w, r;
  int          fails = 0;
  int          tests_run = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  dcdc_core_model dcdc_core_model_inst (.sys_clk_i, .spr_num_o(num), .spr_read_o(srd),
    .spr_write_o(swr), .spr_wdata_o(wd), .acc_valid_o(av), .acc_store_o(ast),
    .acc_addr_o(aa), .acc_data_o(ad));
  dcdc_core dcdc_core_inst (.sys_clk_i, .reset_n_i, .spr_num_i(num), .spr_read_i(srd),
    .spr_write_i(swr), .spr_wdata_i(wd), .spr_rdata_o(rdat), .spr_ack_o(ack),
    .acc_valid_i(av), .acc_store_i(ast), .acc_addr_i(aa), .acc_data_i(ad),
    .addr_a_read_event_o(evt[5]), .addr_a_write_event_o(evt[4]),
    .addr_b_read_event_o(evt[3]), .addr_b_write_event_o(evt[2]),
    .value_a_event_o(evt[1]), .value_b_event_o(evt[0]), .debug_event_status_o(sts));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic ahit(logic [31:0] a, logic [31:0] c, logic [1:0] g);
    logic [4:0] ign;
    ign = (g == 2'h3) ? 5'h1F : (g == 2'h2) ? 5'h03 : {4'h0, g[0]};
    return ((a ^ c) & ~{27'h0, ign}) == 32'h0;
  endfunction : ahit
  // Halfword mode needs both bytes of a half selected
  function automatic logic vhit(logic [31:0] d, logic [31:0] c, logic [3:0] be,
                                logic [1:0] md);
    logic [3:0] eq;
    for (int i = 0; i < 4; i++) eq[i] = d[8*i +: 8] == c[8*i +: 8];
    case (md)
      2'h1: return be != 4'h0 && (eq & be) == be;
      2'h2: return (eq & be) != 4'h0;
      2'h3: return (&be[3:2] && &eq[3:2]) || (&be[1:0] && &eq[1:0]);
      default: return 1'b0;
    endcase
  endfunction : vhit
  task automatic rd(input logic [9:0] n, input logic [31:0] e, input logic k);
    dcdc_core_model_inst.spr(1'b1, 1'b0, n, $urandom);
    chk({31'h0, ack}, {31'h0, k});
    chk(rdat, e);
  endtask : rd
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    dcdc_core_model_inst.spr(1'b0, 1'b1, n, d);
    chk({31'h0, ack}, 32'h1);
  endtask : wr
  task automatic acc(input logic st, input logic [31:0] a, input logic [31:0] d);
    logic ha, hb, inr;
    logic [5:0] ev;
    inr = ((a >= m_a) && (a < m_b)) ^ m_ctrl[CTL_EXCL];
    ha = m_ctrl[CTL_RANGE] ? inr : ahit(a, m_a, m_ctrl[CTL_A_GRAN +: 2]);
    hb = m_ctrl[CTL_RANGE] ? inr : ahit(a, m_b, m_ctrl[CTL_B_GRAN +: 2]);
    ev = {ha & !st & m_ctrl[CTL_A_RD], ha & st & m_ctrl[CTL_A_WR],
          hb & !st & m_ctrl[CTL_B_RD], hb & st & m_ctrl[CTL_B_WR],
          vhit(d, m_va, m_ctrl[CTL_A_BSEL +: 4], m_ctrl[CTL_A_MODE +: 2]),
          vhit(d, m_vb, m_ctrl[CTL_B_BSEL +: 4], m_ctrl[CTL_B_MODE +: 2])};
    m_sts = m_sts | {7'h0, ev[5:2], 21'h0};
    dcdc_core_model_inst.access(st, a, d);
    chk({26'h0, evt}, {26'h0, ev});
    chk(sts, m_sts);
  endtask : acc
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    m_sts = 32'h0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    void'($urandom(70));
    rd(SPR_CTRL, CTL_RESET, 1'b1);
    rd(10'h3BC, 32'h0, 1'b0);
    for (int i = 0; i < 40; i++) begin
      w = $urandom;
      w[CTL_A_GRAN +: 2] = i[1:0];
      w[CTL_B_GRAN +: 2] = i[3:2];
      w[CTL_A_MODE +: 2] = i[1:0];
      w[CTL_B_MODE +: 2] = i[2:1];
      w[CTL_RANGE] = i[2];
      w[CTL_EXCL] = i[3];
      m_ctrl = w & CTL_WMASK;
      m_a = $urandom;
      m_b = m_a + ($urandom & 32'h3F);
      m_va = $urandom;
      m_vb = {m_va[31:16], 16'($urandom)};
      wr(SPR_CTRL, w);
      rd(SPR_CTRL, m_ctrl, 1'b1);
      wr(SPR_ADDR_A, m_a);
      wr(SPR_ADDR_B, m_b);
      wr(SPR_VAL_A, m_va);
      wr(SPR_VAL_B, m_vb);
      rd(SPR_ADDR_B, m_b, 1'b1);
      rd(SPR_VAL_A, m_va, 1'b1);
      repeat (8) begin
        r = $urandom;
        acc(r[4], (r[12] ? m_a : m_b) + {28'h0, r[8:5]} - 32'h4,
            m_va ^ ($urandom & {{8{r[3]}}, {8{r[2]}}, {8{r[1]}}, {8{r[0]}}}));
      end
      rd(SPR_STATUS, m_sts, 1'b1);
      wr(SPR_STATUS, 32'hFFFFFFFF);
      m_sts = 32'h0;
    end
    @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    rd(SPR_CTRL, CTL_RESET, 1'b1);
    rd(SPR_STATUS, STS_RESET, 1'b1);
    end_sim();
  end
endmodule : data_compare_debug_control_tb_top
